/* ras_cfg.svh */
// Purpose: constants for the return address stack
// Assumes: byte offsets on the register bus, one word per register
// Notes: definitions only
`ifndef RAS_CFG_SVH
`define RAS_CFG_SVH
`define RAS_OFF_PTR   32'h0000_0000
`define RAS_OFF_UPR   32'h0000_0004
`define RAS_OFF_HI    32'h0000_0008
`define RAS_OFF_LO    32'h0000_000c
`define RAS_OFF_CFG   32'h0000_0010
`define RAS_DEPTH     31
`define RAS_PC_W      21
`define RAS_PTR_W     5
`define RAS_PTR_EMPTY 5'h00
`define RAS_PTR_ONE   5'h01
`define RAS_PTR_FILL  5'h1e
`define RAS_PTR_LAST  5'h1f
`define RAS_PC_STEP   21'h000002
`define RAS_BIT_FULL  7
`define RAS_BIT_UNF   6
`define RAS_BIT_OVR   0
`define RAS_OVR_RST   1'b1
`define RAS_RESP_OK   2'b00
`define RAS_RESP_ERR  2'b10
`endif

/* ras_pkg.sv */
// Purpose: types of the return address stack
// Assumes: nothing
// Notes: register selector
`default_nettype none
package ras_pkg;
  typedef enum logic [2:0] {
    RAS_SEL_PTR,
    RAS_SEL_UPR,
    RAS_SEL_HI,
    RAS_SEL_LO,
    RAS_SEL_CFG,
    RAS_SEL_NONE
  } ras_sel_t;
endpackage
`default_nettype wire

/* ras_stack_mem.sv */
// Purpose: stack storage, entries 1 to depth
// Assumes: one write port, combinational read
// Notes: index zero has no storage and reads zero
`default_nettype none
module ras_stack_mem #(
  parameter int DEPTH = 31,
  parameter int W     = 21,
  parameter int AW    = 5
) (
  input  wire logic          aclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem_r [1:DEPTH];
  wire          rd_ok = (raddr != '0) && (32'(raddr) <= DEPTH);
  wire          wr_ok = we && (waddr != '0) && (32'(waddr) <= DEPTH);

  assign rdata = rd_ok ? mem_r[raddr] : '0;

  always_ff @(posedge aclk)
  begin
    if (wr_ok)
    begin
      mem_r[waddr] <= wdata;
    end
  end
endmodule // ras_stack_mem
`default_nettype wire

/* ras_axil_slave.sv */
// Purpose: axi4-lite slave front end
// Assumes: address and data offered together
// Notes: write strobe and read sample one cycle after valid
`default_nettype none
`include "ras_cfg.svh"
module ras_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_en,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic             wr_lane0,
  input  wire logic        wr_err,
  output logic [31:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  logic aw_rdy_r;
  logic ar_rdy_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [1:0]  bresp_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  wire  aw_go = s_axi_awvalid && s_axi_wvalid && !aw_rdy_r && !bvalid_r;
  wire  ar_go = s_axi_arvalid && !ar_rdy_r && !rvalid_r;
  wire  rd_en = ar_rdy_r && s_axi_arvalid;

  assign wr_en         = aw_rdy_r && s_axi_awvalid && s_axi_wvalid;
  assign wr_addr       = s_axi_awaddr;
  assign wr_data       = s_axi_wdata;
  assign wr_lane0      = s_axi_wstrb[0];
  assign rd_addr       = s_axi_araddr;
  assign s_axi_awready = aw_rdy_r;
  assign s_axi_wready  = aw_rdy_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ar_rdy_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_rdy_r <= 1'b0;
      ar_rdy_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r  <= `RAS_RESP_OK;
      rresp_r  <= `RAS_RESP_OK;
      rdata_r  <= 32'h0000_0000;
    end
    else
    begin
      aw_rdy_r <= aw_go;
      ar_rdy_r <= ar_go;
      if (wr_en)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_err ? `RAS_RESP_ERR : `RAS_RESP_OK;
      end
      else if (s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
      if (rd_en)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_data;
        rresp_r  <= rd_err ? `RAS_RESP_ERR : `RAS_RESP_OK;
      end
      else if (s_axi_rready)
      begin
        rvalid_r <= 1'b0;
      end
    end
  end
endmodule // ras_axil_slave
`default_nettype wire

/* ras_return_stack.sv */
// Purpose: hardware return address stack of the core
// Assumes: push and pop are one-cycle pulses from the sequencer
// Notes: registers on axi4-lite, fields of up to 8 bits in the low byte
//
// Function
// - up to 31 nested calls and interrupts held in hardware
// - call, relative call or interrupt acknowledge pushes the pc
// - return, return with literal, return from interrupt pop the pc
// - pc latch registers untouched; only pc and stack change
// - storage 31 entries of 21 bits, 5-bit pointer, own space
// - every reset zeroes the pointer; zero selects no entry
// - push increments pointer, then writes pc at new pointer
// - pop moves entry at pointer to pc, then decrements
// - software reads and writes pointer and top entry
// - three top entry bytes track the entry at the pointer
// - pointer register holds pointer, full flag, underflow flag
// - full flag sets after 31 pushes without a pop
// - full flag cleared only by software or power-on reset
// - reset enabled: 31st push stores pc plus 2, resets device
// - reset disabled: pointer stays 31, entry not overwritten
// - pop when empty gives pc zero, sets underflow, pointer zero
// - underflow flag sticky until software or power-on reset
// - enable bit also makes underflow reset the device
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
`include "ras_cfg.svh"
module ras_return_stack #(
  parameter int DEPTH = `RAS_DEPTH,
  parameter int PC_W  = `RAS_PC_W
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            por_rst,
  input  wire logic            push_req,
  input  wire logic [PC_W-1:0] push_pc,
  input  wire logic            pop_req,
  output logic      [PC_W-1:0] pop_pc_r,
  output logic                 pop_valid_r,
  output logic                 dev_reset_r,
  input  wire logic [31:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [31:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);
  // ******************************
  // decode
  // ******************************
  function automatic ras_pkg::ras_sel_t reg_sel(input logic [31:0] a);
    case (a)
      `RAS_OFF_PTR: reg_sel = ras_pkg::RAS_SEL_PTR;
      `RAS_OFF_UPR: reg_sel = ras_pkg::RAS_SEL_UPR;
      `RAS_OFF_HI:  reg_sel = ras_pkg::RAS_SEL_HI;
      `RAS_OFF_LO:  reg_sel = ras_pkg::RAS_SEL_LO;
      `RAS_OFF_CFG: reg_sel = ras_pkg::RAS_SEL_CFG;
      default:      reg_sel = ras_pkg::RAS_SEL_NONE;
    endcase
  endfunction

  logic [`RAS_PTR_W-1:0] ptr_r;
  logic [`RAS_PTR_W-1:0] ptr_nxt;
  logic                  stack_full_flag_r;
  logic                  stack_underflow_flag_r;
  logic                  overflow_reset_enable_r;
  logic [PC_W-1:0]       tos;
  logic                  wr_en;
  logic [31:0]           wr_addr;
  logic [31:0]           wr_data;
  logic                  wr_lane0;
  logic [31:0]           rd_addr;
  logic [31:0]           rd_data;

  wire ras_pkg::ras_sel_t wsel = reg_sel(wr_addr);
  wire ras_pkg::ras_sel_t rsel = reg_sel(rd_addr);

  // ******************************
  // register bus
  // ******************************
  ras_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_lane0      (wr_lane0),
    .wr_err        (wsel == ras_pkg::RAS_SEL_NONE),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rsel == ras_pkg::RAS_SEL_NONE)
  );

  // ******************************
  // stack control
  // ******************************
  wire hw_op    = push_req || pop_req;
  wire sw_wr    = wr_en && wr_lane0 && !hw_op;
  wire sw_ptr   = sw_wr && (wsel == ras_pkg::RAS_SEL_PTR);
  wire sw_cfg   = sw_wr && (wsel == ras_pkg::RAS_SEL_CFG);
  wire sw_tos   = sw_wr && (ptr_r != `RAS_PTR_EMPTY) &&
                  (wsel inside {ras_pkg::RAS_SEL_UPR, ras_pkg::RAS_SEL_HI,
                                ras_pkg::RAS_SEL_LO});
  wire is_empty = (ptr_r == `RAS_PTR_EMPTY);
  wire is_fill  = (ptr_r == `RAS_PTR_FILL);
  wire at_last  = (ptr_r == `RAS_PTR_LAST);
  wire overflow = push_req && (is_fill || at_last);
  wire do_pop   = pop_req && !push_req;
  wire underflw = do_pop && is_empty;
  wire trip     = overflow_reset_enable_r && (overflow || underflw);
  wire [`RAS_PTR_W-1:0] push_addr = ptr_r + `RAS_PTR_ONE;
  wire [PC_W-1:0] push_data = (is_fill && overflow_reset_enable_r) ?
                              PC_W'(push_pc + `RAS_PC_STEP) : push_pc;
  wire mem_push = push_req && !at_last;
  wire [7:0] wb = wr_data[7:0];
  wire [PC_W-1:0] tos_merge =
    (wsel == ras_pkg::RAS_SEL_UPR) ? {wb[4:0], tos[15:0]} :
    (wsel == ras_pkg::RAS_SEL_HI)  ? {tos[20:16], wb, tos[7:0]} :
                                     {tos[20:8], wb};
  wire mem_we = mem_push || sw_tos;
  wire [`RAS_PTR_W-1:0] mem_wa = push_req ? push_addr : ptr_r;
  wire [PC_W-1:0] mem_wd = push_req ? push_data : tos_merge;

  // pointer next value
  assign ptr_nxt =
    push_req ? (overflow ? (overflow_reset_enable_r ? `RAS_PTR_EMPTY
                                                    : `RAS_PTR_LAST)
                         : push_addr) :
    do_pop   ? (is_empty ? `RAS_PTR_EMPTY : ptr_r - `RAS_PTR_ONE) :
    sw_ptr   ? wb[4:0] : ptr_r;

  // flags: hardware set beats software clear
  wire full_nxt = overflow ||
                  (sw_ptr ? wb[`RAS_BIT_FULL] : stack_full_flag_r);
  wire unf_nxt  = underflw ||
                  (sw_ptr ? wb[`RAS_BIT_UNF] : stack_underflow_flag_r);

  // ******************************
  // storage
  // ******************************
  ras_stack_mem #(
    .DEPTH (DEPTH),
    .W     (PC_W),
    .AW    (`RAS_PTR_W)
  ) u_mem (
    .aclk  (aclk),
    .we    (mem_we),
    .waddr (mem_wa),
    .wdata (mem_wd),
    .raddr (ptr_r),
    .rdata (tos)
  );

  // ******************************
  // registers
  // ******************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ptr_r       <= `RAS_PTR_EMPTY;
      pop_pc_r    <= '0;
      pop_valid_r <= 1'b0;
      dev_reset_r <= 1'b0;
    end
    else
    begin
      ptr_r       <= ptr_nxt;
      pop_valid_r <= do_pop;
      dev_reset_r <= trip;
      if (do_pop)
      begin
        pop_pc_r <= is_empty ? '0 : tos;
      end
    end
  end

  // flags survive any reset but power-on
  always_ff @(posedge aclk)
  begin
    if (!aresetn && por_rst)
    begin
      stack_full_flag_r       <= 1'b0;
      stack_underflow_flag_r  <= 1'b0;
      overflow_reset_enable_r <= `RAS_OVR_RST;
    end
    else if (aresetn)
    begin
      stack_full_flag_r      <= full_nxt;
      stack_underflow_flag_r <= unf_nxt;
      if (sw_cfg)
      begin
        overflow_reset_enable_r <= wb[`RAS_BIT_OVR];
      end
    end
  end

  // ******************************
  // read mux
  // ******************************
  wire [7:0] ptr_byte = {stack_full_flag_r, stack_underflow_flag_r, 1'b0, ptr_r};
  assign rd_data =
    (rsel == ras_pkg::RAS_SEL_PTR) ? {24'h00_0000, ptr_byte} :
    (rsel == ras_pkg::RAS_SEL_UPR) ? {27'h000_0000, tos[20:16]} :
    (rsel == ras_pkg::RAS_SEL_HI)  ? {24'h00_0000, tos[15:8]} :
    (rsel == ras_pkg::RAS_SEL_LO)  ? {24'h00_0000, tos[7:0]} :
    (rsel == ras_pkg::RAS_SEL_CFG) ? {31'h0000_0000, overflow_reset_enable_r} :
                                     32'h0000_0000;

  // ******************************
  // checks
  // ******************************
  ptr_zero_a : assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> ptr_r == `RAS_PTR_EMPTY)
    else $error("pointer not zero after reset");

  push_store_a : assert property (@(posedge aclk) disable iff (!aresetn)
    push_req && (ptr_r < `RAS_PTR_FILL) |=>
      ptr_r == $past(ptr_r) + `RAS_PTR_ONE && tos == $past(push_pc))
    else $error("push did not store pc at incremented pointer");

  pop_load_a : assert property (@(posedge aclk) disable iff (!aresetn)
    do_pop && !is_empty |=>
      pop_valid_r && pop_pc_r == $past(tos) && ptr_r == $past(ptr_r) - `RAS_PTR_ONE)
    else $error("pop did not return top entry");

  pop_empty_a : assert property (@(posedge aclk) disable iff (!aresetn)
    do_pop && is_empty |=>
      pop_pc_r == '0 && stack_underflow_flag_r && ptr_r == `RAS_PTR_EMPTY)
    else $error("empty pop mishandled");

  full_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    push_req && is_fill |=> stack_full_flag_r)
    else $error("full flag not set on 31st push");

  ovr_trip_a : assert property (@(posedge aclk) disable iff (!aresetn)
    push_req && is_fill && overflow_reset_enable_r |=>
      dev_reset_r && ptr_r == `RAS_PTR_EMPTY ##1 !dev_reset_r)
    else $error("overflow reset not raised");

  ovr_hold_a : assert property (@(posedge aclk) disable iff (!aresetn)
    push_req && at_last && !overflow_reset_enable_r |=>
      ptr_r == `RAS_PTR_LAST && tos == $past(tos))
    else $error("saturated stack changed");

  full_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    stack_full_flag_r && !sw_ptr |=> stack_full_flag_r)
    else $error("full flag dropped");

  unf_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    stack_underflow_flag_r && !sw_ptr |=> stack_underflow_flag_r)
    else $error("underflow flag dropped");

  unf_trip_a : assert property (@(posedge aclk) disable iff (!aresetn)
    underflw |=> dev_reset_r == $past(overflow_reset_enable_r))
    else $error("underflow reset wrong");

  hw_first_a : assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && push_req && !overflow |=> ptr_r == $past(ptr_r) + `RAS_PTR_ONE)
    else $error("software write beat a push");

  pop_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && !do_pop |=> pop_pc_r == $past(pop_pc_r))
    else $error("popped pc did not hold");

  quiet_cfg_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !overflow_reset_enable_r |=> !dev_reset_r)
    else $error("reset raised while disabled");

  sat_full_a : assert property (@(posedge aclk) disable iff (!aresetn)
    push_req && is_fill && !overflow_reset_enable_r |=>
      stack_full_flag_r && ptr_r == `RAS_PTR_LAST && !dev_reset_r)
    else $error("last push without reset mishandled");
endmodule // ras_return_stack
`default_nettype wire

/* ras_seq_model.sv */
// Purpose: instruction sequencer model on the stack link
// Assumes: requests launched right after a rising edge
// Notes: push_pc shows inverted data after a push
`default_nettype none
module ras_seq_model (
  input  wire logic        aclk,
  output var  logic        push_req,
  output var  logic [20:0] push_pc,
  output var  logic        pop_req,
  input  wire logic [20:0] pop_pc_r,
  input  wire logic        pop_valid_r
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    push_req = 1'b0;
    push_pc  = 21'h000000;
    pop_req  = 1'b0;
  end
  // calls or interrupt entries, n back to back
  task automatic push(input logic [20:0] pc, input int n);
    for (int i = 0; i < n; i++)
    begin
      push_req <= 1'b1;
      push_pc  <= pc + 21'(i);
      @(posedge aclk);
    end
    push_req <= 1'b0;
    push_pc  <= ~(pc + 21'(n - 1));
  endtask
  // any return kind; ok low when no answer came
  task automatic pop(output logic [20:0] pc, output logic ok);
    pop_req <= 1'b1;
    @(posedge aclk);
    pop_req <= 1'b0;
    ok = 1'b0;
    pc = 21'h000000;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge aclk);
      if (pop_valid_r === 1'b1)
      begin
        ok = 1'b1;
        pc = pop_pc_r;
      end
    end
  endtask
endmodule // ras_seq_model
`default_nettype wire

/* return_address_stack_tb_top.sv */
// Purpose: self-checking bench of the return address stack
// Assumes: sequencer model on the link, axi4-lite master tasks
// Notes: one task per scenario
`default_nettype none
`include "ras_cfg.svh"
module return_address_stack_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk;
  logic        aresetn       = 1'b0;
  logic        por_rst       = 1'b1;
  logic [31:0] s_axi_awaddr  = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [31:0] s_axi_araddr  = 32'h0000_0000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  wire  logic  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire  logic [31:0] s_axi_rdata;
  wire  logic        push_req, pop_req, pop_valid_r, dev_reset_r;
  wire  logic [20:0] push_pc, pop_pc_r;
  int          rst_cnt       = 0;
  int          err_count     = 0;
  int          check_count   = 0;

  ras_return_stack dut (.aclk(aclk), .aresetn(aresetn), .por_rst(por_rst),
    .push_req(push_req), .push_pc(push_pc), .pop_req(pop_req), .pop_pc_r(pop_pc_r),
    .pop_valid_r(pop_valid_r), .dev_reset_r(dev_reset_r), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  ras_seq_model seq (.aclk(aclk), .push_req(push_req), .push_pc(push_pc),
    .pop_req(pop_req), .pop_pc_r(pop_pc_r), .pop_valid_r(pop_valid_r));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // counts reset pulses
  always @(posedge aclk)
    if (dev_reset_r === 1'b1)
      rst_cnt <= rst_cnt + 1;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic guard(input int n);
    if (n > 40)
    begin
      err_count++;
      $display("[FAIL] handshake expected answer seen timeout");
      stop_test();
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      guard(n);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      guard(n);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
    if (er === `RAS_RESP_OK)
      chk($sformatf("rdata %h", a), d, s_axi_rdata);
    @(posedge aclk);
  endtask
  task automatic tos_chk(input logic [20:0] v);
    rd_chk(`RAS_OFF_UPR, {27'h0, v[20:16]}, `RAS_RESP_OK);
    rd_chk(`RAS_OFF_HI, {24'h0, v[15:8]}, `RAS_RESP_OK);
    rd_chk(`RAS_OFF_LO, {24'h0, v[7:0]}, `RAS_RESP_OK);
  endtask
  task automatic pop_chk(input logic [20:0] v);
    logic [20:0] pc;
    logic        ok;
    seq.pop(pc, ok);
    chk("pop_valid_r", 32'h1, {31'h0, ok});
    chk("pop_pc_r", {11'h0, v}, {11'h0, pc});
  endtask
  task automatic do_reset(input logic p);
    aresetn <= 1'b0;
    por_rst <= p;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    por_rst <= 1'b0;
    @(posedge aclk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals();
    rd_chk(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
    rd_chk(`RAS_OFF_CFG, 32'h1, `RAS_RESP_OK);
    rd_chk(32'h0000_0014, 32'h0, `RAS_RESP_ERR);
    axi_wr(32'h0000_0014, 32'h0000_00ff, `RAS_RESP_ERR);
    s_axi_wstrb <= 4'he;
    axi_wr(`RAS_OFF_PTR, 32'h0000_0005, `RAS_RESP_OK);
    s_axi_wstrb <= 4'hf;
    rd_chk(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
  endtask
  task automatic t_push_pop();
    seq.push(21'h1a2b3c, 3);
    rd_chk(`RAS_OFF_PTR, 32'h3, `RAS_RESP_OK);
    tos_chk(21'h1a2b3e);
    axi_wr(`RAS_OFF_LO, 32'h5a, `RAS_RESP_OK);
    axi_wr(`RAS_OFF_UPR, 32'he7, `RAS_RESP_OK);
    axi_wr(`RAS_OFF_HI, 32'hc3, `RAS_RESP_OK);
    tos_chk(21'h07c35a);
    pop_chk(21'h07c35a);
    pop_chk(21'h1a2b3d);
    pop_chk(21'h1a2b3c);
    rd_chk(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
  endtask
  task automatic t_collide();
    fork
      axi_wr(`RAS_OFF_PTR, 32'h10, `RAS_RESP_OK);
      seq.push(21'h000100, 8);
    join
    rd_chk(`RAS_OFF_PTR, 32'h8, `RAS_RESP_OK);
    axi_wr(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
  endtask
  task automatic t_underflow();
    int r0;
    axi_wr(`RAS_OFF_CFG, 32'h0, `RAS_RESP_OK);
    r0 = rst_cnt;
    pop_chk(21'h000000);
    rd_chk(`RAS_OFF_PTR, 32'h40, `RAS_RESP_OK);
    chk("dev_reset_r", 32'h0, rst_cnt - r0);
    axi_wr(`RAS_OFF_CFG, 32'h1, `RAS_RESP_OK);
    pop_chk(21'h000000);
    @(posedge aclk);
    chk("dev_reset_r", 32'h1, rst_cnt - r0);
    do_reset(1'b0);
    rd_chk(`RAS_OFF_PTR, 32'h40, `RAS_RESP_OK);
    axi_wr(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
    rd_chk(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
  endtask
  task automatic t_full_off();
    int r0;
    axi_wr(`RAS_OFF_CFG, 32'h0, `RAS_RESP_OK);
    r0 = rst_cnt;
    seq.push(21'h0c0000, 31);
    rd_chk(`RAS_OFF_PTR, 32'h9f, `RAS_RESP_OK);
    seq.push(21'h155555, 1);
    rd_chk(`RAS_OFF_PTR, 32'h9f, `RAS_RESP_OK);
    tos_chk(21'h0c001e);
    chk("dev_reset_r", 32'h0, rst_cnt - r0);
    do_reset(1'b0);
    rd_chk(`RAS_OFF_PTR, 32'h80, `RAS_RESP_OK);
  endtask
  task automatic t_full_on();
    int r0;
    axi_wr(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
    axi_wr(`RAS_OFF_CFG, 32'h1, `RAS_RESP_OK);
    r0 = rst_cnt;
    seq.push(21'h030000, 31);
    rd_chk(`RAS_OFF_PTR, 32'h80, `RAS_RESP_OK);
    chk("dev_reset_r", 32'h1, rst_cnt - r0);
    axi_wr(`RAS_OFF_PTR, 32'h9f, `RAS_RESP_OK);
    tos_chk(21'h03001e + `RAS_PC_STEP);
    do_reset(1'b1);
    rd_chk(`RAS_OFF_PTR, 32'h0, `RAS_RESP_OK);
  endtask

  initial
  begin
    do_reset(1'b1);
    t_reset_vals();
    t_push_pop();
    t_collide();
    t_underflow();
    t_full_off();
    t_full_on();
    stop_test();
  end
endmodule // return_address_stack_tb_top
`default_nettype wire
